// >>> logic/fpm_menu.v
// Purpose: front panel menu controller, session, edits, save prompt
// Assumes: switch levels synchronous to clk, retained store outside
// Notes:   live settings drive the path, saved ones go to the store
`timescale 1ns/10ps
`default_nettype none
`include "fpm_consts.vh"

// Contract
// - edits happen only in a session opened by an execute press, closed by execute or idle timeout
// - horizontal rocker moves the cursor one place left or right
// - vertical rocker raises or lowers the digit under the cursor
// - vertical rocker toggles an on/off item in either direction
// - thirty idle seconds end the session and restore prior settings
// - gain edits apply at once, stored only on Yes
// - execute on return item or after last item goes to save prompt
// - Yes commits all edits, No restores all prior values
// - resolving save prompt returns to the normal display
// - up gain adjusts in 1 dB steps in its menu
// - down gain steps 1 or 10 dB by cursor digit
// - down gain spans 30 to 50 dB
// - execute advances through the menus in fixed order to save prompt
// - alarm whenever any oscillator loop is out of lock
// - committed settings survive power loss and reload at power-up
module fpm_menu
#(
  parameter N_PLL       = 3,
  parameter IDLE_CYCLES = `FPM_IDLE_CYCLES
)
(
  // clock and reset
  input  wire             clk,
  input  wire             resetn,
  // panel switches, high while pressed
  input  wire             sw_exec,
  input  wire             sw_left,
  input  wire             sw_right,
  input  wire             sw_up,
  input  wire             sw_down,
  // loop lock indications, high when locked
  input  wire [N_PLL-1:0] pll_lock,
  // retained store contents at power-up
  input  wire [5:0]       nv_up_gain,
  input  wire [5:0]       nv_dn_gain,
  input  wire             nv_up_mute,
  input  wire             nv_ref_ext,
  input  wire             nv_remote,
  // retained store write
  output reg              nv_wr_q,
  output reg  [5:0]       sv_up_gain_q,
  output reg  [5:0]       sv_dn_gain_q,
  output reg              sv_up_mute_q,
  output reg              sv_ref_ext_q,
  output reg              sv_remote_q,
  // live settings to the signal path
  output reg  [5:0]       up_gain_q,
  output reg  [5:0]       dn_gain_q,
  output reg              up_mute_q,
  output reg              ref_ext_q,
  output reg              remote_q,
  // display state
  output reg  [1:0]       disp_state_q,
  output reg  [2:0]       disp_menu_q,
  output reg  [1:0]       disp_cursor_q,
  // alarm and interrupt
  output reg              alarm_q,
  output reg              irq_q,
  // register port
  input  wire [7:0]       reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [31:0]      reg_rdata_q
);

  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_NORM = 2'h1;
  localparam [1:0] ST_EDIT = 2'h2;
  localparam [1:0] ST_SAVE = 2'h3;

  localparam [1:0] CUR_YES = 2'h0;

  // press pulses
  wire [4:0] press;
  wire       p_exec  = press[0];
  wire       p_left  = press[1];
  wire       p_right = press[2];
  wire       p_up    = press[3];
  wire       p_down  = press[4];
  wire       active  = |press;
  wire       expire;

  fpm_edge
  #(
    .N (5)
  )
  u_edge
  (
    .clk    (clk),
    .resetn (resetn),
    .lvl    ({sw_down, sw_up, sw_right, sw_left, sw_exec}),
    .press  (press)
  );

  fpm_idle_timer
  #(
    .CYCLES (IDLE_CYCLES)
  )
  u_idle
  (
    .clk      (clk),
    .resetn   (resetn),
    .run      (disp_state_q == ST_EDIT || disp_state_q == ST_SAVE),
    .kick     (active),
    .expire_q (expire)
  );

  // highest cursor position, which is the return item
  function [1:0] cur_last;
    input [2:0] menu;
    begin
      if (menu == `FPM_MENU_DNG)
        cur_last = 2'h2;
      else
        cur_last = 2'h1;
    end
  endfunction

  // saturating gain step
  function [5:0] gain_step;
    input [5:0] g;
    input [5:0] step;
    input       up;
    input [5:0] lo;
    input [5:0] hi;
    begin
      if (up)
        gain_step = (g + step > hi) ? hi : g + step;
      else
        gain_step = (g < lo + step) ? lo : g - step;
    end
  endfunction

  wire at_return = (disp_cursor_q == cur_last(disp_menu_q));
  wire vert      = p_up | p_down;
  // down gain cursor 0 is the tens digit
  wire [5:0] dn_step = (disp_cursor_q == 2'h0) ? `FPM_STEP_COARSE : `FPM_STEP_FINE;

  // session state machine and settings
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      disp_state_q  <= ST_BOOT;
      disp_menu_q   <= 3'h0;
      disp_cursor_q <= 2'h0;
      nv_wr_q       <= 1'b0;
      up_gain_q     <= `FPM_UPG_MIN;
      dn_gain_q     <= `FPM_DNG_MIN;
      up_mute_q     <= 1'b0;
      ref_ext_q     <= 1'b0;
      remote_q      <= 1'b0;
      sv_up_gain_q  <= `FPM_UPG_MIN;
      sv_dn_gain_q  <= `FPM_DNG_MIN;
      sv_up_mute_q  <= 1'b0;
      sv_ref_ext_q  <= 1'b0;
      sv_remote_q   <= 1'b0;
    end
    else
    begin
      nv_wr_q <= 1'b0;
      case (disp_state_q)
        ST_BOOT:
        begin
          // retained settings caught after reset release, clamped
          sv_up_gain_q <= (nv_up_gain > `FPM_UPG_MAX) ? `FPM_UPG_MAX : nv_up_gain;
          sv_dn_gain_q <= (nv_dn_gain < `FPM_DNG_MIN) ? `FPM_DNG_MIN :
                          (nv_dn_gain > `FPM_DNG_MAX) ? `FPM_DNG_MAX : nv_dn_gain;
          sv_up_mute_q <= nv_up_mute;
          sv_ref_ext_q <= nv_ref_ext;
          sv_remote_q  <= nv_remote;
          up_gain_q    <= (nv_up_gain > `FPM_UPG_MAX) ? `FPM_UPG_MAX : nv_up_gain;
          dn_gain_q    <= (nv_dn_gain < `FPM_DNG_MIN) ? `FPM_DNG_MIN :
                          (nv_dn_gain > `FPM_DNG_MAX) ? `FPM_DNG_MAX : nv_dn_gain;
          up_mute_q    <= nv_up_mute;
          ref_ext_q    <= nv_ref_ext;
          remote_q     <= nv_remote;
          disp_state_q <= ST_NORM;
        end
        ST_NORM:
        begin
          if (p_exec)
          begin
            disp_state_q  <= ST_EDIT;
            disp_menu_q   <= `FPM_MENU_UPG;
            disp_cursor_q <= 2'h0;
          end
        end
        ST_EDIT:
        begin
          if (expire)
          begin
            // abandon: live values fall back to the saved ones
            up_gain_q    <= sv_up_gain_q;
            dn_gain_q    <= sv_dn_gain_q;
            up_mute_q    <= sv_up_mute_q;
            ref_ext_q    <= sv_ref_ext_q;
            remote_q     <= sv_remote_q;
            disp_state_q <= ST_NORM;
            disp_menu_q  <= 3'h0;
          end
          else if (p_exec)
          begin
            disp_cursor_q <= 2'h0;
            if (at_return || disp_menu_q == `FPM_MENU_REMOTE)
            begin
              disp_state_q  <= ST_SAVE;
              disp_menu_q   <= 3'h6;
              disp_cursor_q <= CUR_YES;
            end
            else
              disp_menu_q <= disp_menu_q + 3'h1;
          end
          else if (p_left)
          begin
            if (disp_cursor_q != 2'h0)
              disp_cursor_q <= disp_cursor_q - 2'h1;
          end
          else if (p_right)
          begin
            if (!at_return)
              disp_cursor_q <= disp_cursor_q + 2'h1;
          end
          else if (vert && !at_return)
          begin
            // edits hit the live path at once, storage waits for Yes
            case (disp_menu_q)
              `FPM_MENU_UPG:
                up_gain_q <= gain_step(up_gain_q, `FPM_STEP_FINE, p_up,
                                       `FPM_UPG_MIN, `FPM_UPG_MAX);
              `FPM_MENU_DNG:
                dn_gain_q <= gain_step(dn_gain_q, dn_step, p_up,
                                       `FPM_DNG_MIN, `FPM_DNG_MAX);
              `FPM_MENU_MUTE:
                up_mute_q <= ~up_mute_q;
              `FPM_MENU_REF:
                ref_ext_q <= ~ref_ext_q;
              `FPM_MENU_REMOTE:
                remote_q  <= ~remote_q;
              default:
                up_mute_q <= up_mute_q;
            endcase
          end
        end
        ST_SAVE:
        begin
          if (expire || p_exec)
          begin
            disp_state_q  <= ST_NORM;
            disp_menu_q   <= 3'h0;
            disp_cursor_q <= 2'h0;
            if (p_exec && !expire && disp_cursor_q == CUR_YES)
            begin
              sv_up_gain_q <= up_gain_q;
              sv_dn_gain_q <= dn_gain_q;
              sv_up_mute_q <= up_mute_q;
              sv_ref_ext_q <= ref_ext_q;
              sv_remote_q  <= remote_q;
              nv_wr_q      <= 1'b1;
            end
            else
            begin
              up_gain_q <= sv_up_gain_q;
              dn_gain_q <= sv_dn_gain_q;
              up_mute_q <= sv_up_mute_q;
              ref_ext_q <= sv_ref_ext_q;
              remote_q  <= sv_remote_q;
            end
          end
          else if (p_left)
            disp_cursor_q <= 2'h0;
          else if (p_right)
            disp_cursor_q <= 2'h1;
        end
        default:
          disp_state_q <= ST_BOOT;
      endcase
    end
  end

  // alarm, events and interrupt
  wire       lock_lost = ~&pll_lock;
  reg  [2:0] status_q;
  reg  [2:0] mask_q;
  wire [2:0] ev;
  wire [2:0] clr;

  assign ev[`FPM_ST_LOCKLOSS] = lock_lost & ~alarm_q;
  assign ev[`FPM_ST_TIMEOUT]  = expire;
  assign ev[`FPM_ST_SAVED]    = nv_wr_q;
  assign clr = (reg_wr && reg_addr == `FPM_REG_STATUS) ? reg_wdata[2:0] : 3'h0;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      alarm_q  <= 1'b0;
      status_q <= 3'h0;
      mask_q   <= `FPM_MASK_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      alarm_q  <= lock_lost;
      // a new event beats a clear in the same cycle
      status_q <= (status_q & ~clr) | ev;
      if (reg_wr && reg_addr == `FPM_REG_MASK)
        mask_q <= reg_wdata[2:0];
      irq_q    <= |(((status_q & ~clr) | ev) & mask_q);
    end
  end

  // register read, answer stands in the following cycle only
  wire [31:0] live_word  = {13'h0, remote_q, ref_ext_q, up_mute_q,
                            2'h0, dn_gain_q, 2'h0, up_gain_q};
  wire [31:0] saved_word = {13'h0, sv_remote_q, sv_ref_ext_q, sv_up_mute_q,
                            2'h0, sv_dn_gain_q, 2'h0, sv_up_gain_q};
  wire [31:0] ui_word;

  generate
    if (N_PLL < 16)
    begin : g_ui_pad
      assign ui_word = {{(16 - N_PLL){1'b0}}, pll_lock, 7'h0, alarm_q,
                        1'b0, disp_menu_q, disp_cursor_q, disp_state_q};
    end
    else
    begin : g_ui_cut
      assign ui_word = {pll_lock[15:0], 7'h0, alarm_q,
                        1'b0, disp_menu_q, disp_cursor_q, disp_state_q};
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!resetn)
      reg_rdata_q <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FPM_REG_STATUS: reg_rdata_q <= {29'h0, status_q};
        `FPM_REG_MASK:   reg_rdata_q <= {29'h0, mask_q};
        `FPM_REG_LIVE:   reg_rdata_q <= live_word;
        `FPM_REG_SAVED:  reg_rdata_q <= saved_word;
        `FPM_REG_UI:     reg_rdata_q <= ui_word;
        default:         reg_rdata_q <= 32'h0;
      endcase
    end
    else
      reg_rdata_q <= 32'h0;
  end

endmodule // fpm_menu
`default_nettype wire

// >>> logic/fpm_consts.vh
// Purpose: shared constants of the front panel menu controller
// Assumes: 50 MHz clock, 32-bit register words at byte offsets
// Notes:   definitions only
`ifndef FPM_CONSTS_VH
`define FPM_CONSTS_VH

// register byte offsets
`define FPM_REG_STATUS    8'h00
`define FPM_REG_MASK      8'h04
`define FPM_REG_LIVE      8'h08
`define FPM_REG_SAVED     8'h0C
`define FPM_REG_UI        8'h10

// status and mask bit positions
`define FPM_ST_LOCKLOSS   0
`define FPM_ST_TIMEOUT    1
`define FPM_ST_SAVED      2
`define FPM_ST_W          3

// settings word field positions
`define FPM_F_UPG_LSB     0
`define FPM_F_DNG_LSB     8
`define FPM_F_MUTE        16
`define FPM_F_REF         17
`define FPM_F_REMOTE      18

// gain limits in dB
`define FPM_UPG_MIN       6'h00
`define FPM_UPG_MAX       6'h1E
`define FPM_DNG_MIN       6'h1E
`define FPM_DNG_MAX       6'h32
`define FPM_STEP_FINE     6'h01
`define FPM_STEP_COARSE   6'h0A

// menu numbers, the save prompt follows the last
`define FPM_MENU_UPG      3'h1
`define FPM_MENU_DNG      3'h2
`define FPM_MENU_MUTE     3'h3
`define FPM_MENU_REF      3'h4
`define FPM_MENU_REMOTE   3'h5

// reset values
`define FPM_MASK_RST      3'h0

// idle timeout
`define FPM_CLK_HZ        50000000
`define FPM_IDLE_TIME_S   30
`define FPM_IDLE_CYCLES   (`FPM_IDLE_TIME_S * `FPM_CLK_HZ)

`endif

// >>> logic/fpm_edge.v
// Purpose: one-cycle press pulses from the panel switch levels
// Assumes: switch levels already debounced and synchronous to clk
// Notes:   a held switch gives one pulse only
`timescale 1ns/10ps
`default_nettype none
module fpm_edge
#(
  parameter N = 5
)
(
  // clock and reset
  input  wire         clk,
  input  wire         resetn,
  // switch levels in, press pulses out
  input  wire [N-1:0] lvl,
  output wire [N-1:0] press
);

  reg [N-1:0] lvl_q;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_edge
      always @(posedge clk)
      begin
        if (!resetn)
          lvl_q[i] <= 1'b0;
        else
          lvl_q[i] <= lvl[i];
      end
      assign press[i] = lvl[i] & ~lvl_q[i];
    end
  endgenerate

endmodule // fpm_edge
`default_nettype wire

// >>> logic/fpm_idle_timer.v
// Purpose: idle timeout for an open edit session
// Assumes: kick is high for one cycle on any switch activity
// Notes:   counter held clear while the session is closed
`timescale 1ns/10ps
`default_nettype none
module fpm_idle_timer
#(
  parameter CYCLES = 1500000000
)
(
  // clock and reset
  input  wire clk,
  input  wire resetn,
  // control
  input  wire run,
  input  wire kick,
  output reg  expire_q
);

  localparam [31:0] LAST = CYCLES - 1;

  reg [31:0] cnt_q;

  always @(posedge clk)
  begin
    if (!resetn || !run || kick)
    begin
      cnt_q    <= 32'h0;
      expire_q <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q    <= 32'h0;
      expire_q <= 1'b1;
    end
    else
    begin
      cnt_q    <= cnt_q + 32'h1;
      expire_q <= 1'b0;
    end
  end

endmodule // fpm_idle_timer
`default_nettype wire

// >>> tb/fpm_store.sv
// Purpose: retained settings store beside the menu controller
// Assumes: written by a one-cycle strobe from the controller
// Notes:   contents survive the controller's reset, like real storage
`timescale 1ns/10ps
`default_nettype none
module fpm_store
(
  // clock
  input  wire logic        clk,
  // write from controller, contents out
  input  wire logic        wr,
  input  wire logic [14:0] d,
  output logic      [14:0] q
);
  // down gain of 25 dB lies below range, so boot must clamp it
  initial q = 15'h064A;

  always @(posedge clk)
  begin
    if (wr)
      q <= d;
  end
endmodule // fpm_store
`default_nettype wire

// >>> tb/fpm_menu_monitor.sv
// Purpose: assertions on the menu controller ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every fpm_menu instance
`timescale 1ns/10ps
`default_nettype none
module fpm_menu_monitor
#(
  parameter N_PLL = 3
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // switches and lock
  input  wire logic             sw_exec,
  input  wire logic             sw_up,
  input  wire logic             sw_down,
  input  wire logic [N_PLL-1:0] pll_lock,
  // design outputs
  input  wire logic             nv_wr_q,
  input  wire logic [5:0]       sv_up_gain_q,
  input  wire logic [5:0]       sv_dn_gain_q,
  input  wire logic [5:0]       up_gain_q,
  input  wire logic [5:0]       dn_gain_q,
  input  wire logic             up_mute_q,
  input  wire logic [1:0]       disp_state_q,
  input  wire logic [2:0]       disp_menu_q,
  input  wire logic [1:0]       disp_cursor_q,
  input  wire logic             alarm_q
);
  wire logic at0;

  assign at0 = (disp_state_q == 2'h2) && (disp_cursor_q == 2'h0);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_alarm_on_loss: assert property (!(&pll_lock) |=> alarm_q)
    else $error("alarm missing");
  a_alarm_clears: assert property (&pll_lock |=> !alarm_q)
    else $error("alarm without lock loss");
  a_normal_frozen: assert property (disp_state_q == 2'h1 |=> $stable(up_gain_q) && $stable(up_mute_q))
    else $error("live setting changed outside session");
  a_up_fine: assert property (at0 && disp_menu_q == 3'h1 && $rose(sw_up) && up_gain_q < 6'h1E
    |=> up_gain_q == $past(up_gain_q) + 6'h01)
    else $error("up gain step wrong");
  a_dn_coarse: assert property (at0 && disp_menu_q == 3'h2 && $rose(sw_up) && dn_gain_q <= 6'h28
    |=> dn_gain_q == $past(dn_gain_q) + 6'h0A)
    else $error("down gain coarse step wrong");
  a_mute_flip: assert property (at0 && disp_menu_q == 3'h3 && ($rose(sw_up) || $rose(sw_down))
    |=> up_mute_q != $past(up_mute_q))
    else $error("mute did not toggle");
  a_exec_advance: assert property (at0 && disp_menu_q < 3'h6 && $rose(sw_exec)
    |=> disp_menu_q == $past(disp_menu_q) + 3'h1)
    else $error("menu order wrong");
  a_save_closes: assert property (disp_state_q == 2'h3 && $rose(sw_exec) |=> disp_state_q == 2'h1)
    else $error("save prompt not closed");
  a_commit_copy: assert property (nv_wr_q |-> sv_up_gain_q == up_gain_q && sv_dn_gain_q == dn_gain_q)
    else $error("commit differs from live");
  a_commit_single: assert property (nv_wr_q |=> !nv_wr_q)
    else $error("store write longer than a cycle");
  a_gain_range: assert property (up_gain_q <= 6'h1E && dn_gain_q >= 6'h1E && dn_gain_q <= 6'h32)
    else $error("gain out of range");

  c_commit: cover property (nv_wr_q);
  c_timeout: cover property (disp_state_q == 2'h2 ##1 disp_state_q == 2'h1);
  c_alarm: cover property ($rose(alarm_q));
endmodule // fpm_menu_monitor

bind fpm_menu fpm_menu_monitor #(.N_PLL(N_PLL)) u_mon
(
  .clk, .resetn, .sw_exec, .sw_up, .sw_down, .pll_lock, .nv_wr_q, .sv_up_gain_q, .sv_dn_gain_q,
  .up_gain_q, .dn_gain_q, .up_mute_q, .disp_state_q, .disp_menu_q, .disp_cursor_q, .alarm_q
);
`default_nettype wire

// >>> tb/fpm_menu_tb.sv
// Purpose: self-checking bench of the front panel menu controller
// Assumes: idle timeout shortened to IDLE cycles
// Notes:   a press holds the switch two cycles, then releases two
`timescale 1ns/10ps
`default_nettype none
`include "fpm_consts.vh"
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module fpm_menu_tb;
  localparam IDLE = 50;
  localparam EX = 4, LF = 3, RT = 2, UP = 1, DN = 0;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  sw = 5'h00;
  logic [2:0]  pll_lock = 3'h7;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [14:0] nv_q;
  logic        nv_wr, mute, ref_ext, remote, sv_mute, sv_ref, sv_rem, alarm, irq;
  logic [5:0]  upg, dng, sv_upg, sv_dng;
  logic [1:0]  st, cur;
  logic [2:0]  menu;
  logic [31:0] rdata;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          i;

  always #10 clk = ~clk;

  fpm_menu #(.N_PLL(3), .IDLE_CYCLES(IDLE)) dut
  (
    .clk(clk), .resetn(resetn), .sw_exec(sw[EX]), .sw_left(sw[LF]), .sw_right(sw[RT]),
    .sw_up(sw[UP]), .sw_down(sw[DN]), .pll_lock(pll_lock), .nv_up_gain(nv_q[5:0]),
    .nv_dn_gain(nv_q[11:6]), .nv_up_mute(nv_q[12]), .nv_ref_ext(nv_q[13]), .nv_remote(nv_q[14]),
    .nv_wr_q(nv_wr), .sv_up_gain_q(sv_upg), .sv_dn_gain_q(sv_dng), .sv_up_mute_q(sv_mute),
    .sv_ref_ext_q(sv_ref), .sv_remote_q(sv_rem), .up_gain_q(upg), .dn_gain_q(dng),
    .up_mute_q(mute), .ref_ext_q(ref_ext), .remote_q(remote), .disp_state_q(st),
    .disp_menu_q(menu), .disp_cursor_q(cur), .alarm_q(alarm), .irq_q(irq),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata)
  );

  fpm_store store
  (
    .clk(clk), .wr(nv_wr), .d({sv_rem, sv_ref, sv_mute, sv_dng, sv_upg}), .q(nv_q)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic press(input int b);
    @(posedge clk);
    sw[b] <= 1'b1;
    repeat (2) @(posedge clk);
    sw[b] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("register read", e, rdata)
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("boot up gain", 6'h0A, upg)
    `CHK("boot down gain clamped", 6'h1E, dng)
    rd(`FPM_REG_LIVE, 32'h00001E0A);
    wr(`FPM_REG_MASK, 32'h00000007);
    rd(`FPM_REG_MASK, 32'h00000007);
    rd(8'h14, 32'h00000000);
    wr(`FPM_REG_LIVE, 32'h00000000);
    rd(`FPM_REG_LIVE, 32'h00001E0A);
    press(UP);
    `CHK("no edit outside session", 6'h0A, upg)
    press(EX);
    `CHK("first menu", 3'h1, menu)
    repeat (21) press(UP);
    `CHK("up gain saturates", 6'h1E, upg)
    `CHK("saved before Yes", 6'h0A, sv_upg)
    press(DN);
    `CHK("up gain down step", 6'h1D, upg)
    press(EX);
    repeat (3) press(UP);
    `CHK("down gain tens", 6'h32, dng)
    press(RT);
    press(DN);
    `CHK("down gain units", 6'h31, dng)
    repeat (2) press(RT);
    `CHK("cursor stops right", 2'h2, cur)
    press(LF);
    `CHK("cursor left", 2'h1, cur)
    press(RT);
    press(EX);
    `CHK("save prompt from return", 3'h6, menu)
    press(EX);
    `CHK("normal display", 2'h1, st)
    `CHK("stored on Yes", 15'h0C5D, nv_q)
    rd(`FPM_REG_STATUS, 32'h00000004);
    `CHK("irq on save", 1'b1, irq)
    wr(`FPM_REG_STATUS, 32'h00000004);
    rd(`FPM_REG_STATUS, 32'h00000000);
    `CHK("irq cleared", 1'b0, irq)
    repeat (3) press(EX);
    press(UP);
    press(DN);
    press(UP);
    `CHK("mute toggled", 1'b1, mute)
    press(EX);
    press(DN);
    `CHK("ref toggled", 1'b1, ref_ext)
    press(EX);
    press(UP);
    `CHK("remote toggled", 1'b1, remote)
    press(EX);
    `CHK("save prompt after last", 3'h6, menu)
    press(RT);
    press(EX);
    `CHK("mute restored", 1'b0, mute)
    `CHK("ref restored", 1'b0, ref_ext)
    `CHK("remote restored", 1'b0, remote)
    `CHK("store kept on No", 15'h0C5D, nv_q)
    press(EX);
    press(UP);
    `CHK("gain applied live", 6'h1E, upg)
    for (i = 0; st !== 2'h1; i++)
    begin
      if (i == 200)
      begin
        n_mismatch++;
        end_of_test();
      end
      @(posedge clk);
      // look after the edge has settled, not in its own time step
      #1;
    end
    #1;
    `CHK("timeout restores gain", 6'h1D, upg)
    rd(`FPM_REG_STATUS, 32'h00000002);
    `CHK("irq on timeout", 1'b1, irq)
    wr(`FPM_REG_MASK, 32'h00000000);
    rd(`FPM_REG_MASK, 32'h00000000);
    `CHK("irq masked", 1'b0, irq)
    wr(`FPM_REG_STATUS, 32'h00000002);
    wr(`FPM_REG_MASK, 32'h00000007);
    @(posedge clk);
    pll_lock <= 3'h5;
    repeat (3) @(posedge clk);
    #1;
    `CHK("alarm on lock loss", 1'b1, alarm)
    rd(`FPM_REG_STATUS, 32'h00000001);
    `CHK("irq on lock loss", 1'b1, irq)
    @(posedge clk);
    pll_lock <= 3'h7;
    repeat (3) @(posedge clk);
    #1;
    `CHK("alarm clears", 1'b0, alarm)
    // second reset: committed settings must come back from the store
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("reload up gain", 6'h1D, upg)
    `CHK("reload down gain", 6'h31, dng)
    rd(`FPM_REG_SAVED, 32'h0000311D);
    rd(`FPM_REG_UI, 32'h00070001);
    end_of_test();
  end
endmodule // fpm_menu_tb
`default_nettype wire
